// *** core/two_wire_slave_status_engine.v ***
// Notes on behaviour
// - general-call data acked reports 0x90, continue
// - general-call data nacked reports 0x98, then unaddressed
// - unaddressed recognition follows ack and gc enable
// - start request with flag clear in a terminal status issues START once the bus is free
// - stop or restart while addressed reports 0xA0
// - match upper seven own-address bits
// - general call only when own-address lsb set
// - direction bit one transmits, zero receives
// - acked address sets flag with status
// - lost arbitration read address reports 0xB0
// - ack cleared sends last byte, C0/C8
// - after last byte release data line
// - ack enable zero ignores own address
// - sleeping interface still matches and acks address
// - sleep match wakes system, stretches until clear
// - data register not updated by address match
// - own read address acked reports 0xA8
// - master-acked byte reports 0xB8, load next
// - 0xC8 means last byte acked anyway
//
// Implementation choices: the strobed register port and the address map.
`include "two_wire_slave_map.vh"
`default_nettype none

module two_wire_slave_status_engine (
  input  wire       core_clk_in,
  input  wire       rst_b_in,
  input  wire [1:0] addr_in,
  input  wire [7:0] wdata_in,
  input  wire       wr_in,
  input  wire       rd_in,
  output reg  [7:0] rdata_out,
  input  wire       scl_in,
  output reg        scl_out,
  output reg        scl_oe_out,
  input  wire       sda_in,
  output reg        sda_out,
  output reg        sda_oe_out,
  input  wire       arb_lost_in,
  input  wire       sleep_in,
  output reg        wake_out,
  output reg        start_issue_out
);

  // states of the slave byte engine
  localparam [3:0] S_IDLE = 4'h0;
  localparam [3:0] S_ADDR = 4'h1;
  localparam [3:0] S_AACK = 4'h2;
  localparam [3:0] S_RX   = 4'h3;
  localparam [3:0] S_RACK = 4'h4;
  localparam [3:0] S_TX   = 4'h5;
  localparam [3:0] S_TACK = 4'h6;
  localparam [3:0] S_HOLD = 4'h7;

  // what to do once software clears the flag
  localparam [1:0] N_RX  = 2'h0;
  localparam [1:0] N_TX  = 2'h1;
  localparam [1:0] N_END = 2'h2;

  reg [3:0] state_r;
  reg [1:0] next_r;
  reg [3:0] bitcnt_r;
  reg [7:0] shift_r;
  reg [7:0] status_r;
  reg [7:0] data_r;
  reg [7:0] own_addr_r;
  reg       flag_r;
  reg       ack_en_r;
  reg       start_req_r;
  reg       stop_req_r;
  reg       wcol_r;
  reg       if_en_r;
  reg       irq_en_r;
  reg       dir_r;
  reg       gc_r;
  reg       ackd_r;
  reg       last_r;
  reg       mack_r;
  reg       busy_r;
  reg       start_pend_r;
  reg       scl_s1_r;
  reg       scl_s2_r;
  reg       scl_d_r;
  reg       sda_s1_r;
  reg       sda_s2_r;
  reg       sda_d_r;

  wire       scl_rise;
  wire       scl_fall;
  wire       start_det;
  wire       stop_det;
  wire       addressed;
  wire       own_hit;
  wire       gc_hit;
  wire       term_st;
  wire       flag_clr;
  wire [7:0] ctrl_rd;

  // bus pins come from outside: two flops before any use
  always @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      scl_s1_r <= 1'b1;
      scl_s2_r <= 1'b1;
      scl_d_r  <= 1'b1;
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
      sda_d_r  <= 1'b1;
    end else begin
      scl_s1_r <= scl_in;
      scl_s2_r <= scl_s1_r;
      scl_d_r  <= scl_s2_r;
      sda_s1_r <= sda_in;
      sda_s2_r <= sda_s1_r;
      sda_d_r  <= sda_s2_r;
    end
  end

  // edges and bus conditions on the synchronised lines
  assign scl_rise  = scl_s2_r & ~scl_d_r;
  assign scl_fall  = ~scl_s2_r & scl_d_r;
  assign start_det = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
  assign stop_det  = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;

  // address compare; general call needs the write direction
  assign own_hit = (shift_r[7:1] == own_addr_r[7:1]);
  assign gc_hit  = (shift_r[7:1] == 7'h00) & own_addr_r[0] & ~shift_r[0];

  // still addressed: a terminal hold is already out of the transfer
  assign addressed = ((state_r >= S_AACK) && (state_r <= S_TACK)) ||
                     ((state_r == S_HOLD) && (next_r != N_END));

  assign term_st = (status_r == `ST_SR_DATA_NACK) || (status_r == `ST_GC_DATA_NACK) ||
                   (status_r == `ST_STOP_RESTART) || (status_r == `ST_ST_DATA_NACK) ||
                   (status_r == `ST_ST_LAST_ACK);

  assign flag_clr = wr_in && (addr_in == `OFS_CONTROL) && wdata_in[`BIT_FLAG];

  assign ctrl_rd = {flag_r, ack_en_r, start_req_r, stop_req_r, wcol_r, if_en_r, 1'b0, irq_en_r};

  // read data stands the cycle after the read strobe only
  always @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_out <= 8'h00;
    end else if (rd_in) begin
      case (addr_in)
        `OFS_CONTROL: rdata_out <= ctrl_rd;
        `OFS_STATUS:  rdata_out <= flag_r ? status_r : `ST_NONE;
        `OFS_DATA:    rdata_out <= data_r;
        default:      rdata_out <= own_addr_r;
      endcase
    end else begin
      rdata_out <= 8'h00;
    end
  end

  // register writes first, engine after, so a hardware set beats a clear
  always @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_r         <= S_IDLE;
      next_r          <= N_END;
      bitcnt_r        <= 4'h0;
      shift_r         <= 8'h00;
      status_r        <= `ST_NONE;
      data_r          <= `RST_DATA;
      own_addr_r      <= `RST_OWN_ADDR;
      flag_r          <= 1'b0;
      ack_en_r        <= 1'b0;
      start_req_r     <= 1'b0;
      stop_req_r      <= 1'b0;
      wcol_r          <= 1'b0;
      if_en_r         <= 1'b0;
      irq_en_r        <= 1'b0;
      dir_r           <= 1'b0;
      gc_r            <= 1'b0;
      ackd_r          <= 1'b0;
      last_r          <= 1'b0;
      mack_r          <= 1'b0;
      busy_r          <= 1'b0;
      start_pend_r    <= 1'b0;
      scl_out         <= 1'b0;
      scl_oe_out      <= 1'b0;
      sda_out         <= 1'b0;
      sda_oe_out      <= 1'b0;
      wake_out        <= 1'b0;
      start_issue_out <= 1'b0;
    end else begin
      start_issue_out <= 1'b0;

      // software side of the register file
      if (wr_in && (addr_in == `OFS_CONTROL)) begin
        ack_en_r    <= wdata_in[`BIT_ACK_EN];
        start_req_r <= wdata_in[`BIT_START_REQ];
        stop_req_r  <= wdata_in[`BIT_STOP_REQ];
        if_en_r     <= wdata_in[`BIT_IF_EN];
        irq_en_r    <= wdata_in[`BIT_IRQ_EN];
        if (wdata_in[`BIT_FLAG]) begin
          flag_r   <= 1'b0;
          wake_out <= 1'b0;
          wcol_r   <= wdata_in[`BIT_WCOL] & wcol_r;
          if (wdata_in[`BIT_START_REQ] && term_st)
            start_pend_r <= 1'b1;
        end
      end
      if (wr_in && (addr_in == `OFS_OWN_ADDR))
        own_addr_r <= wdata_in;
      // the data byte may only change while the engine waits
      if (wr_in && (addr_in == `OFS_DATA)) begin
        if (flag_r)
          data_r <= wdata_in;
        else
          wcol_r <= 1'b1;
      end

      // bus free tracking and the deferred start
      if (start_det)
        busy_r <= 1'b1;
      else if (stop_det)
        busy_r <= 1'b0;
      if (start_pend_r && !busy_r && !flag_r) begin
        start_pend_r    <= 1'b0;
        start_req_r     <= 1'b0;
        start_issue_out <= 1'b1;
      end

      if (!if_en_r) begin
        // disabled: stay off the bus entirely
        state_r    <= S_IDLE;
        scl_oe_out <= 1'b0;
        sda_oe_out <= 1'b0;
      end else if (start_det || stop_det) begin
        if (addressed) begin
          status_r <= `ST_STOP_RESTART;
          flag_r   <= 1'b1;
          next_r   <= N_END;
        end
        state_r    <= start_det ? S_ADDR : S_IDLE;
        bitcnt_r   <= 4'h0;
        scl_oe_out <= 1'b0;
        sda_oe_out <= 1'b0;
      end else begin
        case (state_r)
          S_ADDR: begin
            if (scl_rise) begin
              shift_r  <= {shift_r[6:0], sda_s2_r};
              bitcnt_r <= bitcnt_r + 4'h1;
            end else if (scl_fall && (bitcnt_r == 4'h8)) begin
              // ack only when enabled; bus is still watched otherwise
              if (ack_en_r && (own_hit || gc_hit)) begin
                sda_oe_out <= 1'b1;
                dir_r      <= shift_r[0];
                gc_r       <= gc_hit & ~own_hit;
                state_r    <= S_AACK;
              end else begin
                state_r <= S_IDLE;
              end
            end
          end
          S_AACK: begin
            if (scl_fall) begin
              // address byte is not copied to data
              sda_oe_out <= 1'b0;
              flag_r     <= 1'b1;
              scl_oe_out <= 1'b1;
              state_r    <= S_HOLD;
              if (sleep_in)
                wake_out <= 1'b1;
              if (dir_r) begin
                status_r <= arb_lost_in ? `ST_ST_OWN_ARB : `ST_ST_OWN;
                next_r   <= N_TX;
              end else begin
                if (gc_r)
                  status_r <= arb_lost_in ? `ST_SR_GC_ARB : `ST_SR_GC;
                else
                  status_r <= arb_lost_in ? `ST_SR_OWN_ARB : `ST_SR_OWN;
                next_r <= N_RX;
              end
            end
          end
          S_RX: begin
            if (scl_rise) begin
              shift_r  <= {shift_r[6:0], sda_s2_r};
              bitcnt_r <= bitcnt_r + 4'h1;
            end else if (scl_fall && (bitcnt_r == 4'h8)) begin
              // ack enable decides the answer to this byte
              ackd_r     <= ack_en_r;
              sda_oe_out <= ack_en_r;
              state_r    <= S_RACK;
            end
          end
          S_RACK: begin
            if (scl_fall) begin
              sda_oe_out <= 1'b0;
              data_r     <= shift_r;
              flag_r     <= 1'b1;
              scl_oe_out <= 1'b1;
              state_r    <= S_HOLD;
              next_r     <= ackd_r ? N_RX : N_END;
              if (gc_r)
                status_r <= ackd_r ? `ST_GC_DATA_ACK : `ST_GC_DATA_NACK;
              else
                status_r <= ackd_r ? `ST_SR_DATA_ACK : `ST_SR_DATA_NACK;
            end
          end
          S_TX: begin
            if (scl_fall) begin
              if (bitcnt_r == 4'h7) begin
                sda_oe_out <= 1'b0;
                state_r    <= S_TACK;
              end else begin
                shift_r    <= {shift_r[6:0], 1'b1};
                sda_oe_out <= ~shift_r[6];
                bitcnt_r   <= bitcnt_r + 4'h1;
              end
            end
          end
          S_TACK: begin
            if (scl_rise) begin
              mack_r <= ~sda_s2_r;
            end else if (scl_fall) begin
              flag_r     <= 1'b1;
              scl_oe_out <= 1'b1;
              state_r    <= S_HOLD;
              if (!mack_r)
                status_r <= `ST_ST_DATA_NACK;
              else if (last_r)
                status_r <= `ST_ST_LAST_ACK;
              else
                status_r <= `ST_ST_DATA_ACK;
              next_r <= (mack_r && !last_r) ? N_TX : N_END;
            end
          end
          S_HOLD: begin
            // clock stays low until software writes one to the flag
            if (!flag_r) begin
              scl_oe_out <= 1'b0;
              bitcnt_r   <= 4'h0;
              case (next_r)
                N_RX: begin
                  state_r <= S_RX;
                end
                N_TX: begin
                  // first bit goes out in the same cycle the clock is released
                  shift_r    <= data_r;
                  sda_oe_out <= ~data_r[7];
                  last_r     <= ~ack_en_r;
                  state_r    <= S_TX;
                end
                default: begin
                  // data line left released: master reads ones
                  sda_oe_out <= 1'b0;
                  state_r    <= S_IDLE;
                end
              endcase
            end
          end
          default: begin
            // unaddressed: watch only, wait for a start
            sda_oe_out <= 1'b0;
            scl_oe_out <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// *** core/two_wire_slave_map.vh ***
`ifndef TWO_WIRE_SLAVE_MAP_VH
`define TWO_WIRE_SLAVE_MAP_VH

// register word offsets on the plain register port
`define OFS_CONTROL      2'h0
`define OFS_STATUS       2'h1
`define OFS_DATA         2'h2
`define OFS_OWN_ADDR     2'h3

// control register bit positions
`define BIT_FLAG         7
`define BIT_ACK_EN       6
`define BIT_START_REQ    5
`define BIT_STOP_REQ     4
`define BIT_WCOL         3
`define BIT_IF_EN        2
`define BIT_IRQ_EN       0

// reset values
`define RST_CONTROL      8'h00
`define RST_OWN_ADDR     8'h00
`define RST_DATA         8'hFF

// status codes, prescaler bits always zero
`define ST_NONE          8'hF8
`define ST_SR_OWN        8'h60
`define ST_SR_OWN_ARB    8'h68
`define ST_SR_GC         8'h70
`define ST_SR_GC_ARB     8'h78
`define ST_SR_DATA_ACK   8'h80
`define ST_SR_DATA_NACK  8'h88
`define ST_GC_DATA_ACK   8'h90
`define ST_GC_DATA_NACK  8'h98
`define ST_STOP_RESTART  8'hA0
`define ST_ST_OWN        8'hA8
`define ST_ST_OWN_ARB    8'hB0
`define ST_ST_DATA_ACK   8'hB8
`define ST_ST_DATA_NACK  8'hC0
`define ST_ST_LAST_ACK   8'hC8

`endif

// *** tb/two_wire_slave_status_engine_properties.sv ***
`default_nettype none
`include "two_wire_slave_map.vh"
module two_wire_slave_checker (
  input wire logic       core_clk_in,
  input wire logic       rst_b_in,
  input wire logic [1:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic       wr_in,
  input wire logic       rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic       scl_in,
  input wire logic       scl_out,
  input wire logic       scl_oe_out,
  input wire logic       sda_out,
  input wire logic       sda_oe_out,
  input wire logic       sleep_in,
  input wire logic       wake_out,
  input wire logic       start_issue_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       clr_w;
  logic       st_rd;
  logic [1:0] clr_hist_r;
  assign clr_w = wr_in && addr_in == `OFS_CONTROL && wdata_in[`BIT_FLAG];
  assign st_rd = rd_in && addr_in == `OFS_STATUS;
  // the stretch release trails a flag clear by two cycles, so recent clears are remembered
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      clr_hist_r <= 2'h0;
    end else begin
      clr_hist_r <= {clr_hist_r[0], clr_w};
    end
  end
  default clocking @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_b_in);
  sequence s_clear;
    clr_w && scl_oe_out;
  endsequence
  sequence s_release;
    ##[1:3] !scl_oe_out;
  endsequence
  AST_STRETCH_HOLD: assert property (scl_oe_out && !clr_w && clr_hist_r == 2'h0 |=> scl_oe_out)
    else $error("bus clock released with the flag still set");
  AST_STRETCH_RELEASE: assert property (s_clear |-> s_release)
    else $error("bus clock still held after the flag clear");
  AST_STRETCH_STATUS: assert property (st_rd && scl_oe_out && clr_hist_r == 2'h0 |=> rdata_out != `ST_NONE)
    else $error("idle status read during a stretch");
  AST_PRESCALER_ZERO: assert property (st_rd |=> rdata_out[2:0] == 3'h0)
    else $error("status low bits not zero");
  AST_STRETCH_SDA_FREE: assert property ($rose(scl_oe_out) |-> !sda_oe_out)
    else $error("data line held when the stretch began");
  AST_SDA_WITH_SCL_LOW: assert property ($changed(sda_oe_out) |-> !$past(scl_in))
    else $error("data line moved while the bus clock was high");
  AST_WAKE_CAUSE: assert property ($rose(wake_out) |-> $past(sleep_in))
    else $error("wake raised outside sleep");
  AST_WAKE_UNTIL_CLEAR: assert property ($fell(scl_oe_out) |-> !wake_out)
    else $error("stretch ended while still waking");
  AST_START_PULSE: assert property (start_issue_out |=> !start_issue_out)
    else $error("start pulse longer than one cycle");
  AST_START_BUS_FREE: assert property (start_issue_out |-> !scl_oe_out && !sda_oe_out)
    else $error("start pulse while lines held");
  // open-drain lines: only the enables may pull, the data value stays low
  AST_LINES_OPEN_DRAIN: assert property (!scl_out && !sda_out)
    else $error("line data value driven high");
endmodule
bind two_wire_slave_status_engine two_wire_slave_checker i_chk (
  .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
  .rd_in(rd_in), .rdata_out(rdata_out), .scl_in(scl_in), .scl_out(scl_out), .scl_oe_out(scl_oe_out),
  .sda_out(sda_out), .sda_oe_out(sda_oe_out),
  .sleep_in(sleep_in), .wake_out(wake_out), .start_issue_out(start_issue_out));
`default_nettype wire

// *** tb/bus_master_model.sv ***
`default_nettype none
module bus_master_model (
  input  wire logic scl_in,
  input  wire logic sda_in,
  output var  logic scl_low_out,
  output var  logic sda_low_out,
  output var  logic stuck_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int   n;
  logic r;
  initial begin
    scl_low_out = 1'b0;
    sda_low_out = 1'b0;
    stuck_out = 1'b0;
  end
  // release the clock, wait out a stretch (bounded), then hold it high
  task automatic rise();
    scl_low_out = 1'b0;
    for (n = 0; scl_in !== 1'b1 && n < 9000; n++) #8;
    if (n == 9000) stuck_out = 1'b1;
    #80;
  endtask
  // one bit: line set in mid-low, sampled at the end of the high phase
  task automatic slot(input logic b, output logic s);
    sda_low_out = !b;
    #40;
    rise();
    s = sda_in;
    scl_low_out = 1'b1;
    #40;
  endtask
  // idle gap first so the slave sees a free bus after the last stop
  task automatic start_c();
    #80;
    sda_low_out = 1'b1;
    #80;
    scl_low_out = 1'b1;
    #40;
  endtask
  // no trailing idle, so a start pulse right after the stop is not missed
  task automatic stop_c();
    sda_low_out = 1'b1;
    #40;
    rise();
    sda_low_out = 1'b0;
  endtask
  task automatic send(input logic [7:0] v, output logic ack);
    for (int i = 7; i >= 0; i--) slot(v[i], r);
    slot(1'b1, r);
    ack = !r;
  endtask
  task automatic recv(input logic ack_in, output logic [7:0] v);
    for (int i = 7; i >= 0; i--) slot(1'b1, v[i]);
    slot(!ack_in, r);
  endtask
endmodule
`default_nettype wire

// *** tb/tb_two_wire_slave_status_engine.sv ***
`default_nettype none
`include "two_wire_slave_map.vh"
module tb_two_wire_slave_status_engine;
  timeunit 1ns;
  timeprecision 1ps;
  logic       core_clk_in, rst_b_in, wr_in, rd_in, arb_lost_in, sleep_in, ack;
  logic [1:0] addr_in;
  logic [7:0] wdata_in, d;
  wire  [7:0] rdata_out;
  wire        scl_oe_out, sda_oe_out, wake_out, start_issue_out, m_scl_low, m_sda_low, m_stuck, scl_w, sda_w;
  int         miscompares, n_checks, n;
  // open-drain lines with pull-ups
  assign scl_w = !(scl_oe_out || m_scl_low);
  assign sda_w = !(sda_oe_out || m_sda_low);
  two_wire_slave_status_engine i_dut (
    .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
    .rd_in(rd_in), .rdata_out(rdata_out), .scl_in(scl_w), .scl_out(), .scl_oe_out(scl_oe_out),
    .sda_in(sda_w), .sda_out(), .sda_oe_out(sda_oe_out), .arb_lost_in(arb_lost_in), .sleep_in(sleep_in),
    .wake_out(wake_out), .start_issue_out(start_issue_out));
  bus_master_model i_master (
    .scl_in(scl_w), .sda_in(sda_w), .scl_low_out(m_scl_low), .sda_low_out(m_sda_low), .stuck_out(m_stuck));
  initial begin
    core_clk_in = 1'b0;
    forever #4 core_clk_in = ~core_clk_in;
  end
  task automatic close_out();
    if (miscompares == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge core_clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= v;
    @(posedge core_clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, output logic [7:0] v);
    @(posedge core_clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge core_clk_in);
    rd_in <= 1'b0;
    #1 v = rdata_out;
  endtask
  task automatic rc(input logic [1:0] a, input logic [7:0] e);
    rd(a, d);
    chk(d, e);
  endtask
  // poll status until the flag shows, bounded
  task automatic wait_st(input logic [7:0] e);
    d = `ST_NONE;
    for (n = 0; n < 40 && d === `ST_NONE; n++) rd(`OFS_STATUS, d);
    chk(d, e);
    if (d === `ST_NONE) close_out();
  endtask
  task automatic address(input logic [7:0] b, input logic e);
    i_master.start_c();
    i_master.send(b, ack);
    chk({7'h0, ack}, {7'h0, e});
  endtask
  always @(posedge m_stuck) begin
    miscompares++;
    close_out();
  end
  initial begin
    {wr_in, rd_in, arb_lost_in, sleep_in} = 4'h0;
    addr_in = 2'h0;
    wdata_in = 8'h00;
    rst_b_in = 1'b0;
    repeat (4) @(posedge core_clk_in);
    rst_b_in <= 1'b1;
    // reset contents; a data write with the flag clear is refused
    rc(`OFS_STATUS, `ST_NONE);
    rc(`OFS_CONTROL, 8'h00);
    rc(`OFS_OWN_ADDR, 8'h00);
    wr(`OFS_DATA, 8'h11);
    rc(`OFS_DATA, 8'hFF);
    rc(`OFS_CONTROL, 8'h08);
    wr(`OFS_OWN_ADDR, 8'hA5);
    wr(`OFS_CONTROL, 8'hC4);
    rc(`OFS_CONTROL, 8'h44);
    // own write address; a zero write keeps the flag; stop while addressed
    address(8'hA4, 1'b1);
    wait_st(`ST_SR_OWN);
    wr(`OFS_CONTROL, 8'h44);
    rc(`OFS_STATUS, `ST_SR_OWN);
    wr(`OFS_CONTROL, 8'hC4);
    i_master.send(8'h3C, ack);
    wait_st(`ST_SR_DATA_ACK);
    rc(`OFS_DATA, 8'h3C);
    wr(`OFS_CONTROL, 8'hC4);
    i_master.stop_c();
    wait_st(`ST_STOP_RESTART);
    wr(`OFS_CONTROL, 8'hC4);
    // general call: acked byte, refused byte, then a start request
    address(8'h00, 1'b1);
    wait_st(`ST_SR_GC);
    wr(`OFS_CONTROL, 8'hC4);
    i_master.send(8'h5A, ack);
    wait_st(`ST_GC_DATA_ACK);
    rc(`OFS_DATA, 8'h5A);
    wr(`OFS_CONTROL, 8'h84);
    i_master.send(8'h66, ack);
    chk({7'h0, ack}, 8'h00);
    wait_st(`ST_GC_DATA_NACK);
    wr(`OFS_CONTROL, 8'hE4);
    i_master.stop_c();
    for (n = 0; n < 100 && start_issue_out !== 1'b1; n++) @(posedge core_clk_in) #1;
    chk({7'h0, start_issue_out}, 8'h01);
    rc(`OFS_CONTROL, 8'h44);
    // transmit: acked byte, last byte acked anyway, then all ones
    address(8'hA5, 1'b1);
    wait_st(`ST_ST_OWN);
    wr(`OFS_DATA, 8'hC3);
    wr(`OFS_CONTROL, 8'hC4);
    i_master.recv(1'b1, d);
    chk(d, 8'hC3);
    wait_st(`ST_ST_DATA_ACK);
    wr(`OFS_DATA, 8'h5A);
    wr(`OFS_CONTROL, 8'h84);
    i_master.recv(1'b1, d);
    chk(d, 8'h5A);
    wait_st(`ST_ST_LAST_ACK);
    wr(`OFS_CONTROL, 8'hC4);
    i_master.recv(1'b0, d);
    chk(d, 8'hFF);
    i_master.stop_c();
    rc(`OFS_STATUS, `ST_NONE);
    // read after lost arbitration; master refuses the last byte
    @(posedge core_clk_in);
    arb_lost_in <= 1'b1;
    address(8'hA5, 1'b1);
    wait_st(`ST_ST_OWN_ARB);
    arb_lost_in <= 1'b0;
    wr(`OFS_DATA, 8'h0F);
    wr(`OFS_CONTROL, 8'h84);
    i_master.recv(1'b0, d);
    chk(d, 8'h0F);
    wait_st(`ST_ST_DATA_NACK);
    wr(`OFS_CONTROL, 8'h84);
    i_master.stop_c();
    address(8'hA4, 1'b0);
    i_master.stop_c();
    // sleep match wakes and stretches until the flag is cleared
    wr(`OFS_CONTROL, 8'h44);
    sleep_in <= 1'b1;
    address(8'hA4, 1'b1);
    wait_st(`ST_SR_OWN);
    chk({6'h0, wake_out, scl_oe_out}, 8'h03);
    wr(`OFS_CONTROL, 8'hC4);
    sleep_in <= 1'b0;
    repeat (3) @(posedge core_clk_in);
    #1 chk({6'h0, wake_out, scl_oe_out}, 8'h00);
    i_master.stop_c();
    wait_st(`ST_STOP_RESTART);
    wr(`OFS_CONTROL, 8'hC4);
    // general call disabled, then a foreign address
    wr(`OFS_OWN_ADDR, 8'hA4);
    address(8'h00, 1'b0);
    i_master.stop_c();
    address(8'hA6, 1'b0);
    i_master.stop_c();
    close_out();
  end
endmodule
`default_nettype wire
